/* File: fp_unit_address_and_mantissa_path_tb_top.sv */
/* Self-checking bench for the address and mantissa datapath.
   Assumes the memory model answers every request. */
`timescale 1ns/1ns
`default_nettype none
module fp_unit_address_and_mantissa_path_tb_top;
  import fpadp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  fpadp_master_ctl_type mc = '0;
  fpadp_fp_ctl_type fc = '0;
  fpadp_master_ctl_type m;
  fpadp_fp_ctl_type f;
  logic [15:0] din = 16'h0000;
  logic [15:0] word = 16'h0000;
  logic [2:0] ra = 3'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic resume, req, mwr, cc, hold, busy, dval;
  logic [15:0] rdata, dout, maddr, wdat, rdo, v, p, d, w0, w1, w2;
  logic [0:51] acc_o, md, acc, sec, r;
  logic [15:0] rq[$];
  logic [15:0] dq[$];
  logic [7:0] tbl [12] = '{8'hC4, 8'h24, 8'h41, 8'h64, 8'h94, 8'h04, 8'hA4, 8'hE4,
                           8'h84, 8'h08, 8'h0C, 8'hC4};
  int err_total = 0;
  int n_compared = 0;
  int i;
  integer seed = 90;

  fpadp_top dut (.core_clk_i(clk), .reset_i(rst), .master_ctl_i(mc), .fp_ctl_i(fc),
    .data_i(din), .data_o(dout), .data_valid_o(dval), .mem_resume_i(resume),
    .mem_rdata_i(rdata), .mem_req_o(req), .mem_write_o(mwr), .mem_consec_o(cc),
    .mem_scan_hold_o(hold), .mem_addr_o(maddr), .mem_wdata_o(wdat), .mem_busy_o(busy),
    .reg_addr_i(ra), .reg_wdata_i(din), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdo), .accumulator_o(acc_o));
  fpadp_mem_model u_mem (.clk_i(clk), .req_i(req), .word_i(word), .resume_o(resume),
    .rdata_o(rdata));

  // ----------------
  // Helpers
  // ----------------
  task chk(input logic [51:0] s, e, input string n);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Idle edge after each op keeps strobes one cycle long
  task cyc(input fpadp_master_ctl_type c, input logic [2:0] a, input logic [15:0] dd,
           input logic w, rr);
    mc <= c;
    ra <= a;
    din <= dd;
    wr <= w;
    rd <= rr;
    @(posedge clk);
    mc <= '0;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task go(input fpadp_master_ctl_type c);
    cyc(c, 3'h0, 16'h0000, 1'b0, 1'b0);
  endtask
  task rdr(input fpadp_master_ctl_type c, input logic [2:0] a, input logic [15:0] e);
    rq.push_back(e);
    cyc(c, a, 16'h0000, 1'b0, 1'b1);
  endtask
  task fcyc(input fpadp_fp_ctl_type c);
    fc <= c;
    @(posedge clk);
    fc <= '0;
    @(posedge clk);
  endtask
  task idle_wait;
    int j;
    for (j = 0; j < 60 && busy !== 1'b0; j++) @(posedge clk);
    if (j == 60) begin
      err_total++;
      conclude;
    end
  endtask
  function automatic logic [0:51] alu(input fpadp_alu_fn_type fn, input logic [0:51] a, b);
    logic [0:51] y;
    case (fn)
      FPADP_ALU_ARITH_A: y = (&a) ? '0 : a;
      FPADP_ALU_A_DEC: y = a - 1'b1;
      FPADP_ALU_LOGIC_A: y = a;
      FPADP_ALU_NOT_A: y = ~a;
      FPADP_ALU_ADD: y = a + b;
      FPADP_ALU_SUB: y = a - b;
      FPADP_ALU_B: y = b;
      default: y = ~b;
    endcase
    y[48:51] = {4{y[0]}};
    return y;
  endfunction

  initial forever #50 clk = ~clk;
  always @(negedge clk) begin
    if (rd_d) chk(52'(rdo), 52'(rq.pop_front()), "reg_rdata");
    if (dval === 1'b1) chk(52'(dout), 52'(dq.pop_front()), "data_o");
    rd_d <= rd;
  end

  // ----------------
  // Scenarios
  // ----------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    m = '0;
    rdr(m, FPADP_REG_CONFIG, 16'h0001);
    cyc(m, FPADP_REG_STATUS, 16'hFFFF, 1'b1, 1'b0);
    rdr(m, FPADP_REG_STATUS, 16'h0000);
    rdr(m, 3'h6, 16'h0000);
    v = $random(seed);
    p = $random(seed);
    d = $random(seed);
    cyc(m, FPADP_REG_INDEX, v, 1'b1, 1'b0);
    cyc(m, FPADP_REG_SELECTED, p, 1'b1, 1'b0);
    rdr(m, FPADP_REG_SELECTED, p);
    m.select_index = 1'b1;
    w0 = {v[14:0], v[15]};
    for (i = 1; i < 4; i++) begin
      m.scale = fpadp_scale_type'(i);
      rdr(m, FPADP_REG_SELECTED, i == 1 ? v : i == 2 ? w0 : 16'(v + w0));
    end
    m = '0;
    m.ld_temp = 1'b1;
    cyc(m, 3'h0, d, 1'b0, 1'b0);
    rdr('0, FPADP_REG_TEMP, d);
    m.alu_add = 1'b1;
    cyc(m, 3'h0, d, 1'b0, 1'b0);
    rdr('0, FPADP_REG_TEMP, d + p);
    m = '0;
    m.inc_temp = 1'b1;
    m.inc_pc = 1'b1;
    go(m);
    rdr('0, FPADP_REG_TEMP, d + p + 16'h0001);
    rdr('0, FPADP_REG_SELECTED, p + 16'h0001);
    $display("Test address path done");
    word = $random(seed);
    m = '0;
    m.mem_cmd = FPADP_MEM_READ_CC;
    m.addr_from_temp = 1'b1;
    m.alu_add = 1'b1;
    m.select_index = 1'b1;
    m.scale = FPADP_SCALE_X1;
    dq.push_back(word);
    go(m);
    @(negedge clk);
    chk(52'({req, mwr, cc, hold, maddr}),
        52'({4'b1011, 16'(d + p + 1 + v)}), "mem read");
    idle_wait;
    m.mem_cmd = FPADP_MEM_WRITE_HOLD;
    m.alu_add = 1'b0;
    cyc(m, 3'h0, word, 1'b0, 1'b0);
    @(negedge clk);
    chk(52'({req, mwr, cc, hold, maddr, wdat}),
        52'({4'b1101, 16'(d + p + 1), word}), "mem write");
    idle_wait;
    $display("Test memory channel done");
    for (i = 0; i < 8; i++) begin
      m = '0;
      m.buf_wr = (i < 4);
      m.buf_rd = (i >= 4);
      m.buf_word = i[1:0];
      if (i >= 4) dq.push_back(16'(16'h1111 * (i - 3)));
      cyc(m, 3'h0, 16'(16'h1111 * (i + 1)), 1'b0, 1'b0);
    end
    m = '0;
    m.status_ld = 1'b1;
    cyc(m, 3'h0, 16'hFFFF, 1'b0, 1'b0);
    m = '0;
    m.set_mode = 1'b1;
    m.set_protect = 1'b1;
    m.set_active = 1'b1;
    m.count_inc = 1'b1;
    go(m);
    m = '0;
    m.count_inc = 1'b1;
    go(m);
    go(m);
    m = '0;
    m.status_rd = 1'b1;
    dq.push_back(16'h034E);
    go(m);
    rdr('0, FPADP_REG_STATUS, 16'h8FDE);
    m = '0;
    m.status_ld = 1'b1;
    go(m);
    m = '0;
    m.set_end = 1'b1;
    m.clr_active = 1'b1;
    m.count_inc = 1'b1;
    m.count_clr = 1'b1;
    go(m);
    rdr('0, FPADP_REG_STATUS, 16'h00D0);
    m = '0;
    m.cmd_ld = 1'b1;
    cyc(m, 3'h0, 16'h1234, 1'b0, 1'b0);
    m = '0;
    m.cmd_shift = 1'b1;
    go(m);
    m = '0;
    m.cmd_rd = 1'b1;
    dq.push_back(16'h2340);
    go(m);
    $display("Test status and command done");
    w0 = $random(seed) & 16'h7FFF;
    w1 = $random(seed);
    w2 = $random(seed);
    for (i = 0; i < 3; i++) begin
      m = '0;
      m.md_ld = 3'(1 << i);
      cyc(m, 3'h0, i == 0 ? w0 : i == 1 ? w1 : w2, 1'b0, 1'b0);
    end
    md = {w0, w1, w2, 4'h0};
    acc = '0;
    sec = '0;
    for (i = 0; i < 12; i++) begin
      f = {1'b1, tbl[i][4], tbl[i][7:5], tbl[i][3:2], tbl[i][1:0], 2'b00};
      r = alu(f.alu_fn, acc, f.b_from_secondary ? sec : md);
      if (f.sec_op == 2'h1) sec = r;
      if (f.acc_op == FPADP_SH_LOAD) acc = r;
      if (f.acc_op == FPADP_SH_LEFT) acc = {acc[0:8], acc[10:51], acc[0]};
      if (f.acc_op == FPADP_SH_RIGHT) acc = {acc[0:8], acc[0], acc[9:50]};
      fcyc(f);
      chk(acc_o, acc, "accumulator");
    end
    for (i = 0; i < 3; i++) begin
      m = '0;
      m.acc_rd = 1'b1;
      m.acc_word = i[1:0];
      dq.push_back(acc[16 * i +: 16]);
      go(m);
    end
    cyc('0, FPADP_REG_CONFIG, 16'h0000, 1'b1, 1'b0);
    f.alu_fn = FPADP_ALU_NOT_B;
    f.acc_op = FPADP_SH_LOAD;
    fcyc(f);
    chk(acc_o, {~w0, ~w1, {20{1'b1}}}, "single fill");
    $display("Test mantissa done");
    conclude;
  end
endmodule
bind fpadp_top fpadp_chk #(.DOUBLE_OPTION(DOUBLE_OPTION)) u_chk (.core_clk_i, .reset_i,
  .master_ctl_i, .fp_ctl_i, .reg_rd_i, .reg_rdata_o, .data_o, .data_valid_o, .mem_req_o,
  .mem_write_o, .mem_busy_o, .accumulator_o);
`default_nettype wire

/* File: fpadp_asserts.sv */
/* Checker for gated outputs, memory requests and mantissa shifts.
   Bound to fpadp_top; sees its ports only, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module fpadp_chk
  import fpadp_pkg::*;
#(parameter bit DOUBLE_OPTION = 1'b1) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Watched ports
  input wire fpadp_master_ctl_type master_ctl_i,
  input wire fpadp_fp_ctl_type fp_ctl_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [15:0] data_o,
  input wire logic data_valid_o,
  input wire logic mem_req_o,
  input wire logic mem_write_o,
  input wire logic mem_busy_o,
  input wire logic [0:51] accumulator_o
);
  // ----------------
  // Properties
  // ----------------
  wire fpadp_master_ctl_type m = master_ctl_i;
  wire fpadp_fp_ctl_type f = fp_ctl_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  AST_RD_ZERO: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data not zero");
  AST_STATUS_RD: assert property ($past(m.status_rd && !m.buf_rd && !mem_busy_o)
    |-> data_valid_o && (data_o & ~FPADP_FSR_LOAD_MASK) == 16'h0000)
    else $error("status gate shows extra bits");
  AST_MEM_REQ: assert property ($past(m.mem_cmd != FPADP_MEM_NONE && !mem_busy_o)
    |-> mem_req_o && mem_busy_o && mem_write_o == $past(m.mem_cmd inside
    {FPADP_MEM_WRITE, FPADP_MEM_WRITE_CC, FPADP_MEM_WRITE_HOLD}))
    else $error("memory request wrong");
  AST_ACC_GATE: assert property ($past(m.acc_rd && !m.buf_rd && !m.status_rd && !m.cmd_rd
    && !f.running && !mem_busy_o && m.acc_word == 2'h0 && !accumulator_o[0])
    |-> data_valid_o && data_o == $past(accumulator_o[0:15]))
    else $error("accumulator gate wrong");
  AST_ACC_LEFT: assert property ($past(f.running && f.acc_op == FPADP_SH_LEFT)
    |-> accumulator_o[0] == $past(accumulator_o[0])
    && accumulator_o[9:34] == $past(accumulator_o[10:35])
    && accumulator_o[DOUBLE_OPTION ? 51 : 35] == $past(accumulator_o[0]))
    else $error("left rotate wrong");
  AST_ACC_RIGHT: assert property ($past(f.running && f.acc_op == FPADP_SH_RIGHT
    && !f.multiply_phase) |-> accumulator_o[0] == $past(accumulator_o[0])
    && accumulator_o[9] == $past(accumulator_o[0])
    && accumulator_o[10:51] == $past(accumulator_o[9:50]))
    else $error("right shift wrong");
  AST_ACC_FILL: assert property ($past(f.running && f.acc_op == FPADP_SH_LOAD)
    |-> accumulator_o[48:51] == {4{accumulator_o[0]}})
    else $error("sign fill wrong");
  AST_ACC_HOLD: assert property ($past(f.running && f.acc_op == FPADP_SH_HOLD)
    |-> $stable(accumulator_o))
    else $error("accumulator moved on hold");
endmodule
`default_nettype wire

/* File: fpadp_mem_model.sv */
/* Far side of the memory channel: answers each request late.
   Assumes requests are levels on the core clock. */
`timescale 1ns/1ns
`default_nettype none
module fpadp_mem_model (
  // Clock and channel
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [15:0] word_i,
  output logic resume_o,
  output logic [15:0] rdata_o
);
  int lat = 2;
  int i;
  initial begin
    resume_o = 1'b0;
    rdata_o = 16'h0000;
    forever begin
      @(posedge clk_i);
      if (req_i) begin
        // Alternate prompt and slow answers
        lat = (lat == 2) ? 7 : 2;
        repeat (lat) @(posedge clk_i);
        rdata_o <= word_i;
        resume_o <= 1'b1;
        for (i = 0; i < 40 && req_i; i++) @(posedge clk_i);
        resume_o <= 1'b0;
        // Released lines must not look valid
        rdata_o <= ~word_i;
      end
    end
  end
endmodule
`default_nettype wire

/* File: fpadp_pkg.sv */
/*
  Shared constants and carrier types for the floating-point address
  and mantissa datapath.
  Assumes one sequencer clock and a plain register port.
*/
package fpadp_pkg;

  // --------
  // Register port map (word index on reg_addr_i)
  // --------
  localparam logic [2:0] FPADP_REG_SELECTED = 3'h0;
  localparam logic [2:0] FPADP_REG_INDEX = 3'h1;
  localparam logic [2:0] FPADP_REG_CONFIG = 3'h2;
  localparam logic [2:0] FPADP_REG_STATUS = 3'h3;
  localparam logic [2:0] FPADP_REG_COMMAND = 3'h4;
  localparam logic [2:0] FPADP_REG_TEMP = 3'h5;
  localparam int FPADP_CFG_DOUBLE_BIT = 0;

  // --------
  // Status word fields and reset values
  // --------
  localparam logic [15:0] FPADP_FSR_LOAD_MASK = 16'h034E;
  localparam int FPADP_FSR_MODE_BIT = 4;
  localparam int FPADP_FSR_END_BIT = 6;
  localparam int FPADP_FSR_PROTECT_BIT = 7;
  localparam int FPADP_FSR_COUNT_LSB = 10;
  localparam int FPADP_FSR_ACTIVE_BIT = 15;
  localparam logic [15:0] FPADP_FSR_RESET = 16'h0000;
  localparam logic [15:0] FPADP_WORD_RESET = 16'h0000;
  localparam int FPADP_CCR_SHIFT = 4;

  // --------
  // Mantissa layout (bit 0 is the sign, bit 51 the least significant)
  // --------
  localparam int FPADP_MANT_MSB = 9;
  localparam int FPADP_MANT_LSB = 51;
  localparam int FPADP_SHORT_LSB = 35;
  localparam int FPADP_SINGLE_FILL = 32;
  localparam int FPADP_DOUBLE_FILL = 48;

  // --------
  // Enumerations
  // --------
  typedef enum logic [1:0] {FPADP_SCALE_X1 = 2'h1, FPADP_SCALE_X2 = 2'h2,
                            FPADP_SCALE_X3 = 2'h3} fpadp_scale_type;
  typedef enum logic [2:0] {FPADP_ALU_ARITH_A = 3'h0, FPADP_ALU_A_DEC = 3'h1,
                            FPADP_ALU_LOGIC_A = 3'h2, FPADP_ALU_NOT_A = 3'h3,
                            FPADP_ALU_ADD = 3'h4, FPADP_ALU_SUB = 3'h5,
                            FPADP_ALU_B = 3'h6, FPADP_ALU_NOT_B = 3'h7} fpadp_alu_fn_type;
  typedef enum logic [1:0] {FPADP_SH_HOLD = 2'h0, FPADP_SH_LOAD = 2'h1,
                            FPADP_SH_LEFT = 2'h2, FPADP_SH_RIGHT = 2'h3} fpadp_shift_op_type;
  typedef enum logic [2:0] {FPADP_MEM_NONE = 3'h0, FPADP_MEM_READ = 3'h1,
                            FPADP_MEM_READ_REL = 3'h2, FPADP_MEM_WRITE = 3'h3,
                            FPADP_MEM_READ_CC = 3'h4, FPADP_MEM_READ_HOLD = 3'h5,
                            FPADP_MEM_WRITE_CC = 3'h6, FPADP_MEM_WRITE_HOLD = 3'h7} fpadp_mem_cmd_type;
  typedef enum logic [1:0] {FPADP_MST_IDLE = 2'b01, FPADP_MST_WAIT = 2'b10} fpadp_mem_state_type;

  // --------
  // Master sequencer controls (one cycle each unless noted)
  // --------
  typedef struct packed {
    logic addr_from_temp;
    logic select_index;
    fpadp_scale_type scale;
    logic alu_add;
    logic ld_pc;
    logic inc_pc;
    logic ld_temp;
    logic inc_temp;
    logic ld_index;
    logic clr_index;
    fpadp_mem_cmd_type mem_cmd;
    logic buf_wr;
    logic buf_rd;
    logic [1:0] buf_word;
    logic status_ld;
    logic status_rd;
    logic set_end;
    logic set_mode;
    logic set_protect;
    logic set_active;
    logic clr_active;
    logic count_inc;
    logic count_clr;
    logic cmd_ld;
    logic cmd_shift;
    logic cmd_rd;
    logic [2:0] md_ld;
    logic [1:0] acc_word;
    logic acc_rd;
  } fpadp_master_ctl_type;

  // Floating-point sequencer controls
  typedef struct packed {
    logic running;
    logic b_from_secondary;
    fpadp_alu_fn_type alu_fn;
    fpadp_shift_op_type acc_op;
    logic [1:0] sec_op;
    logic multiply_phase;
    logic sign_hold_ld;
  } fpadp_fp_ctl_type;

endpackage

/* File: fpadp_top.sv */
/*
  Address preparation, status, command and mantissa datapath of the
  floating-point unit, steered by the master and floating-point sequencers.
  Assumes both sequencers run on core_clk_i; memory channel pins are
  asynchronous and pass two flip-flops first.
*/
// Chosen here: the address-and-strobe port and the address map.
// How it works
// - Scale unit takes index on A and index rotated left on B.
// - Scale one passes A, two selects B, three adds A and B.
// - Selector picks counter or scaled index for reads and address adds.
// - Absolute load routes data lines through the address adder unchanged.
// - Relative load adds data lines and program counter into temp address.
// - Issued address is temp plus scaled index, or temp alone, gated out.
// - Temp and counter load and increment; index loads and clears.
// - Save word and look-ahead words share one four-word memory.
// - Status bits 1,2,3,6,8,9 load and read; end flag sets alone.
// - Memory channel requests read or write, consecutive cycles, scanner hold.
// - Sequencer sets mode, protect and active bits, and clears active.
// - Status bits 10 and 11 count operand bytes; increment and clear.
// - Command register loads, shifts left four per command, reads back.
// - Multiplicand register loads in three 16-bit sections.
// - Mantissa B selects multiplicand or secondary; accumulator drives A.
// - Mantissa unit offers eight functions.
// - Logical A passes A; arithmetic A turns negative zero positive.
// - Accumulator and secondary register load, shift left, shift right.
// - Stopped floating-point sequencer holds unit in arithmetic A.
// - Single fills bits 32 to 51 with sign; double fills 48 to 51.
// - Right shifts copy sign into bit 9; multiply enters sign-hold at bit 0.
// - Accumulator left shift rotates sign into bit 51, or 35 without double option.
`timescale 1ns/1ns
`default_nettype none

module fpadp_top
  import fpadp_pkg::*;
#(
  parameter bit DOUBLE_OPTION = 1'b1
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Sequencer controls and internal data lines
  input wire fpadp_master_ctl_type master_ctl_i,
  input wire fpadp_fp_ctl_type fp_ctl_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_valid_o,
  // Memory channel pins
  input wire logic mem_resume_i,
  input wire logic [15:0] mem_rdata_i,
  output logic mem_req_o,
  output logic mem_write_o,
  output logic mem_consec_o,
  output logic mem_scan_hold_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  output logic mem_busy_o,
  // Register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Mantissa accumulator view
  output logic [0:51] accumulator_o
);

  // --------
  // State
  // --------
  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] index;
    logic [15:0] temp;
    logic [15:0] status;
    logic [15:0] command;
    logic [3:0][15:0] words;
    logic [0:47] md;
    logic [0:51] acc;
    logic [0:51] sec;
    logic sign_hold;
    logic double_mode;
    logic [15:0] rdata;
    logic [15:0] dout;
    logic dvalid;
    fpadp_mem_state_type mstate;
    logic req;
    logic wr;
    logic consec;
    logic hold;
    logic [15:0] maddr;
    logic [15:0] mwdata;
    logic resume_s1;
    logic resume_s2;
    logic resume_prev;
    logic [15:0] rdat_s1;
    logic [15:0] rdat_s2;
  } fpadp_state_type;

  fpadp_state_type state_r;
  fpadp_state_type state_nxt;

  // --------
  // Helpers
  // --------
  function automatic logic [0:51] fill_sign(input logic [0:51] v, input logic dbl);
    logic [0:51] r;
    r = v;
    for (int k = FPADP_SINGLE_FILL; k <= FPADP_MANT_LSB; k++) begin
      if (!dbl || k >= FPADP_DOUBLE_FILL) begin
        r[k] = v[0];
      end
    end
    return r;
  endfunction

  // Arithmetic right shift; bits 1 to 8 belong to the exponent and stay
  function automatic logic [0:51] shift_right(input logic [0:51] v, input logic top);
    logic [0:51] r;
    r = v;
    r[0] = top;
    r[FPADP_MANT_MSB] = v[0];
    for (int k = FPADP_MANT_MSB + 1; k <= FPADP_MANT_LSB; k++) begin
      r[k] = v[k - 1];
    end
    return r;
  endfunction

  function automatic logic [0:51] shift_left(input logic [0:51] v, input int low,
                                             input logic fill);
    logic [0:51] r;
    r = v;
    for (int k = FPADP_MANT_MSB; k < FPADP_MANT_LSB; k++) begin
      if (k < low) begin
        r[k] = v[k + 1];
      end
    end
    r[low] = fill;
    return r;
  endfunction

  // --------
  // Address preparation
  // --------
  logic [15:0] scale_a;
  logic [15:0] scale_b;
  logic [15:0] scaled_index;
  logic [15:0] selected;
  logic [15:0] adder_a;
  logic [15:0] adder_out;

  always_comb begin
    scale_a = state_r.index;
    scale_b = {state_r.index[14:0], state_r.index[15]};
    unique case (master_ctl_i.scale)
      FPADP_SCALE_X2: scaled_index = scale_b;
      FPADP_SCALE_X3: scaled_index = 16'(scale_a + scale_b);
      default: scaled_index = scale_a;
    endcase
    selected = master_ctl_i.select_index ? scaled_index : state_r.pc;
    adder_a = master_ctl_i.addr_from_temp ? state_r.temp : data_i;
    adder_out = master_ctl_i.alu_add ? 16'(adder_a + selected) : adder_a;
  end

  // --------
  // Mantissa unit
  // --------
  fpadp_alu_fn_type alu_fn;
  logic [0:51] alu_b;
  logic [0:51] alu_out;
  logic long_lsb;

  always_comb begin
    alu_fn = fp_ctl_i.running ? fp_ctl_i.alu_fn : FPADP_ALU_ARITH_A;
    alu_b = fp_ctl_i.b_from_secondary ? state_r.sec
          : fill_sign({state_r.md, 4'h0}, state_r.double_mode);
    unique case (alu_fn)
      FPADP_ALU_ARITH_A: alu_out = (&state_r.acc) ? '0 : state_r.acc;
      FPADP_ALU_A_DEC: alu_out = 52'(state_r.acc - 52'h1);
      FPADP_ALU_LOGIC_A: alu_out = state_r.acc;
      FPADP_ALU_NOT_A: alu_out = ~state_r.acc;
      FPADP_ALU_ADD: alu_out = 52'(state_r.acc + alu_b);
      FPADP_ALU_SUB: alu_out = 52'(state_r.acc - alu_b);
      FPADP_ALU_B: alu_out = alu_b;
      FPADP_ALU_NOT_B: alu_out = ~alu_b;
    endcase
    long_lsb = DOUBLE_OPTION ? 1'b1 : 1'b0;
  end

  // --------
  // Next state
  // --------
  always_comb begin
    state_nxt = state_r;
    state_nxt.dvalid = 1'b0;

    // Program counter, temp address, index
    if (master_ctl_i.ld_pc) begin
      state_nxt.pc = adder_out;
    end else if (master_ctl_i.inc_pc) begin
      state_nxt.pc = 16'(state_r.pc + 16'h1);
    end
    if (master_ctl_i.ld_temp) begin
      state_nxt.temp = adder_out;
    end else if (master_ctl_i.inc_temp) begin
      state_nxt.temp = 16'(state_r.temp + 16'h1);
    end
    if (master_ctl_i.clr_index) begin
      state_nxt.index = FPADP_WORD_RESET;
    end else if (master_ctl_i.ld_index) begin
      state_nxt.index = adder_out;
    end

    // Save word and look-ahead memory
    if (master_ctl_i.buf_wr) begin
      state_nxt.words[master_ctl_i.buf_word] = data_i;
    end

    // Status word; sets are applied last so they win over clears
    if (master_ctl_i.status_ld) begin
      state_nxt.status = (state_r.status & ~FPADP_FSR_LOAD_MASK)
                       | (data_i & FPADP_FSR_LOAD_MASK);
    end
    if (master_ctl_i.count_clr) begin
      state_nxt.status[FPADP_FSR_COUNT_LSB +: 2] = 2'h0;
    end else if (master_ctl_i.count_inc) begin
      state_nxt.status[FPADP_FSR_COUNT_LSB +: 2] =
        2'(state_r.status[FPADP_FSR_COUNT_LSB +: 2] + 2'h1);
    end
    if (master_ctl_i.clr_active) begin
      state_nxt.status[FPADP_FSR_ACTIVE_BIT] = 1'b0;
    end
    if (master_ctl_i.set_active) begin
      state_nxt.status[FPADP_FSR_ACTIVE_BIT] = 1'b1;
    end
    if (master_ctl_i.set_mode) begin
      state_nxt.status[FPADP_FSR_MODE_BIT] = 1'b1;
    end
    if (master_ctl_i.set_protect) begin
      state_nxt.status[FPADP_FSR_PROTECT_BIT] = 1'b1;
    end
    if (master_ctl_i.set_end) begin
      state_nxt.status[FPADP_FSR_END_BIT] = 1'b1;
    end

    // Current command
    if (master_ctl_i.cmd_ld) begin
      state_nxt.command = data_i;
    end else if (master_ctl_i.cmd_shift) begin
      state_nxt.command = {state_r.command[15-FPADP_CCR_SHIFT:0],
                           FPADP_CCR_SHIFT'(0)};
    end

    // Multiplicand sections
    for (int s = 0; s < 3; s++) begin
      if (master_ctl_i.md_ld[s]) begin
        state_nxt.md[16*s +: 16] = data_i;
      end
    end

    // Sign-hold latch
    if (fp_ctl_i.sign_hold_ld) begin
      state_nxt.sign_hold = alu_out[0];
    end

    // Accumulator
    unique case (fp_ctl_i.acc_op)
      FPADP_SH_LOAD: state_nxt.acc = fill_sign(alu_out, state_r.double_mode);
      FPADP_SH_LEFT: begin
        state_nxt.acc = shift_left(state_r.acc,
                                   long_lsb ? FPADP_MANT_LSB : FPADP_SHORT_LSB,
                                   state_r.acc[0]);
      end
      FPADP_SH_RIGHT: begin
        state_nxt.acc = shift_right(state_r.acc, fp_ctl_i.multiply_phase
                                    ? state_r.sign_hold : state_r.acc[0]);
      end
      default: state_nxt.acc = state_r.acc;
    endcase

    // Secondary mantissa; left shift feeds zero at the low end
    unique case (fpadp_shift_op_type'(fp_ctl_i.sec_op))
      FPADP_SH_LOAD: state_nxt.sec = fill_sign(alu_out, state_r.double_mode);
      FPADP_SH_LEFT: state_nxt.sec = shift_left(state_r.sec, FPADP_MANT_LSB, 1'b0);
      FPADP_SH_RIGHT: state_nxt.sec = shift_right(state_r.sec, state_r.sec[0]);
      default: state_nxt.sec = state_r.sec;
    endcase

    // Register port; reads answer in the next cycle
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        FPADP_REG_SELECTED: state_nxt.pc = reg_wdata_i;
        FPADP_REG_INDEX: state_nxt.index = reg_wdata_i;
        FPADP_REG_CONFIG: state_nxt.double_mode = reg_wdata_i[FPADP_CFG_DOUBLE_BIT];
        default: ;
      endcase
    end
    state_nxt.rdata = FPADP_WORD_RESET;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        FPADP_REG_SELECTED: state_nxt.rdata = selected;
        FPADP_REG_INDEX: state_nxt.rdata = state_r.index;
        FPADP_REG_CONFIG: state_nxt.rdata = {15'h0, state_r.double_mode};
        FPADP_REG_STATUS: state_nxt.rdata = state_r.status;
        FPADP_REG_COMMAND: state_nxt.rdata = state_r.command;
        FPADP_REG_TEMP: state_nxt.rdata = state_r.temp;
        default: state_nxt.rdata = FPADP_WORD_RESET;
      endcase
    end

    // Data-line gates, first requested wins
    if (master_ctl_i.buf_rd) begin
      state_nxt.dout = state_r.words[master_ctl_i.buf_word];
      state_nxt.dvalid = 1'b1;
    end else if (master_ctl_i.status_rd) begin
      state_nxt.dout = state_r.status & FPADP_FSR_LOAD_MASK;
      state_nxt.dvalid = 1'b1;
    end else if (master_ctl_i.cmd_rd) begin
      state_nxt.dout = state_r.command;
      state_nxt.dvalid = 1'b1;
    end else if (master_ctl_i.acc_rd) begin
      state_nxt.dout = alu_out[16*master_ctl_i.acc_word +: 16];
      state_nxt.dvalid = 1'b1;
    end

    // Memory channel; resume edge comes from synchronised pin
    state_nxt.resume_s1 = mem_resume_i;
    state_nxt.resume_s2 = state_r.resume_s1;
    state_nxt.resume_prev = state_r.resume_s2;
    state_nxt.rdat_s1 = mem_rdata_i;
    state_nxt.rdat_s2 = state_r.rdat_s1;
    unique case (state_r.mstate)
      FPADP_MST_IDLE: begin
        if (master_ctl_i.mem_cmd != FPADP_MEM_NONE) begin
          state_nxt.mstate = FPADP_MST_WAIT;
          state_nxt.req = 1'b1;
          state_nxt.wr = master_ctl_i.mem_cmd inside {FPADP_MEM_WRITE,
                         FPADP_MEM_WRITE_CC, FPADP_MEM_WRITE_HOLD};
          state_nxt.consec = master_ctl_i.mem_cmd inside {FPADP_MEM_READ_CC,
                             FPADP_MEM_WRITE_CC};
          state_nxt.hold = master_ctl_i.mem_cmd inside {FPADP_MEM_READ_CC,
                           FPADP_MEM_READ_HOLD, FPADP_MEM_WRITE_CC,
                           FPADP_MEM_WRITE_HOLD};
          state_nxt.maddr = adder_out;
          state_nxt.mwdata = data_i;
        end
      end
      FPADP_MST_WAIT: begin
        if (state_r.resume_s2 && !state_r.resume_prev) begin
          if (!state_r.wr) begin
            state_nxt.dout = state_r.rdat_s2;
            state_nxt.dvalid = 1'b1;
          end
          if (state_r.consec && master_ctl_i.mem_cmd != FPADP_MEM_NONE) begin
            state_nxt.maddr = adder_out;
            state_nxt.mwdata = data_i;
          end else begin
            state_nxt.mstate = FPADP_MST_IDLE;
            state_nxt.req = 1'b0;
            state_nxt.consec = 1'b0;
            // Hold is kept past the end of a request only while a memory command is present
            state_nxt.hold = state_r.hold && master_ctl_i.mem_cmd != FPADP_MEM_NONE;
          end
        end
      end
    endcase
  end

  // --------
  // Registers
  // --------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= '0;
      state_r.status <= FPADP_FSR_RESET;
      state_r.double_mode <= 1'b1;
      state_r.mstate <= FPADP_MST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // --------
  // Outputs
  // --------
  assign data_o = state_r.dout;
  assign data_valid_o = state_r.dvalid;
  assign mem_req_o = state_r.req;
  assign mem_write_o = state_r.wr;
  assign mem_consec_o = state_r.consec;
  assign mem_scan_hold_o = state_r.hold;
  assign mem_addr_o = state_r.maddr;
  assign mem_wdata_o = state_r.mwdata;
  assign mem_busy_o = state_r.mstate == FPADP_MST_WAIT;
  assign reg_rdata_o = state_r.rdata;
  assign accumulator_o = state_r.acc;

endmodule

`default_nettype wire
